// ===== design/tbms_pkg.sv
// token bucket meter/shaper: shared constants, register map and types
// assumes a single datapath clock; byte addresses on a 32-bit avalon-mm slave
package tbms_pkg;
  localparam int OCC_W = 48;
  localparam int FRAC_W = 16;
  localparam int LEN_W = 16;
  localparam int BKT_W = 24;
  localparam int RATE_W = 32;
  localparam int TIME_W = 32;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ST_W = 3;
  localparam int CTRL_W = 2;
  localparam int BIT_SH = 3;

  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_BUCKET = 5'h04;
  localparam logic [ADDR_W-1:0] REG_RATE = 5'h08;
  localparam logic [ADDR_W-1:0] REG_OCC = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] REG_MASK = 5'h14;
  localparam logic [ADDR_W-1:0] REG_TICK = 5'h18;

  localparam int CTRL_STRICT_BIT = 0;
  localparam int CTRL_SHAPE_BIT = 1;
  localparam int ST_CONFORM_BIT = 0;
  localparam int ST_NONCONF_BIT = 1;
  localparam int ST_RELEASE_BIT = 2;

  localparam logic [CTRL_W-1:0] RST_CTRL = 2'h0;
  localparam logic [BKT_W-1:0] RST_BUCKET = 24'h002ee0;
  localparam logic [RATE_W-1:0] RST_RATE = 32'h00010000;
  localparam logic [ST_W-1:0] RST_MASK = 3'h0;
  localparam logic signed [OCC_W-1:0] RST_OCC =
    {{(OCC_W-BKT_W-FRAC_W+BIT_SH){1'b0}}, RST_BUCKET, {(FRAC_W-BIT_SH){1'b0}}};

  typedef enum logic {
    TBMS_IDLE = 1'b0,
    TBMS_HOLD = 1'b1
  } tbms_shp_t;
endpackage

// ===== design/tbms_top.sv
// token bucket meter and shaper with avalon-mm register slave
// assumes packet inputs synchronous to i_clk; one arrival per cycle at most
`timescale 1ns/1ps
module tbms_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [tbms_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [tbms_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [tbms_pkg::BE_W-1:0] i_avs_byteenable,
  output logic [tbms_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_pkt_valid,
  input wire logic [tbms_pkg::LEN_W-1:0] i_pkt_len,
  output logic o_pkt_ready,
  output logic o_verdict_valid,
  output logic o_verdict_conform,
  output logic o_release_valid,
  output logic [tbms_pkg::TIME_W-1:0] o_release_eligible_time,
  output logic o_irq
);
  import tbms_pkg::*;

  function automatic logic signed [OCC_W-1:0] len_fix(input logic [LEN_W-1:0] len);
    len_fix = $signed({{(OCC_W-LEN_W-FRAC_W){1'b0}}, len, {FRAC_W{1'b0}}});
  endfunction

  function automatic logic signed [OCC_W-1:0] bkt_fix(input logic [BKT_W-1:0] bits);
    logic [BKT_W-1:0] eff;
    eff = (bits == '0) ? {{(BKT_W-1){1'b0}}, 1'b1} : bits;
    bkt_fix = $signed({{(OCC_W-BKT_W-FRAC_W+BIT_SH){1'b0}}, eff, {(FRAC_W-BIT_SH){1'b0}}});
  endfunction

  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // register slave state
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [BKT_W-1:0] bkt_q, bkt_d;
  logic [RATE_W-1:0] rate_q, rate_d;
  logic [ST_W-1:0] mask_q, mask_d, st_q, st_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic irq_q, irq_d;
  logic wr_take;
  logic wr_bucket;
  logic [ST_W-1:0] st_clr;
  logic [DATA_W-1:0] wmerged;

  // meter state
  logic signed [OCC_W-1:0] occ_q, occ_d;
  logic signed [OCC_W-1:0] sum, cred, bfix, lfix, pfix, rate_x;
  tbms_shp_t shp_q, shp_d;
  logic [LEN_W-1:0] plen_q, plen_d;
  logic [TIME_W-1:0] tick_q, tick_d, time_q, time_d;
  logic ready_q, ready_d;
  logic vld_q, vld_d, conf_q, conf_d, rel_q, rel_d;
  logic [ST_W-1:0] ev;
  logic arrive;
  logic strict;
  logic shape;

  assign wr_take = i_avs_write && !wait_q;
  assign wr_bucket = wr_take && (i_avs_address == REG_BUCKET);
  assign strict = ctrl_q[CTRL_STRICT_BIT];
  assign shape = ctrl_q[CTRL_SHAPE_BIT];
  assign arrive = i_pkt_valid && ready_q;
  assign bfix = bkt_fix(bkt_q);
  assign lfix = len_fix(i_pkt_len);
  assign pfix = len_fix(plen_q);
  assign rate_x = $signed({{(OCC_W-RATE_W){1'b0}}, rate_q});
  assign sum = occ_q + rate_x;
  assign cred = (sum > bfix) ? bfix : sum;

  always_comb begin
    ctrl_d = ctrl_q;
    bkt_d = bkt_q;
    rate_d = rate_q;
    mask_d = mask_q;
    st_clr = '0;
    rdata_d = rdata_q;
    wmerged = '0;
    // one wait cycle, then a single-cycle answer
    wait_d = !((i_avs_read || i_avs_write) && wait_q);
    if (wr_take) begin
      case (i_avs_address)
        REG_CTRL: begin
          wmerged = be_merge({{(DATA_W-CTRL_W){1'b0}}, ctrl_q}, i_avs_writedata, i_avs_byteenable);
          ctrl_d = wmerged[CTRL_W-1:0];
        end
        REG_BUCKET: begin
          wmerged = be_merge({{(DATA_W-BKT_W){1'b0}}, bkt_q}, i_avs_writedata, i_avs_byteenable);
          bkt_d = wmerged[BKT_W-1:0];
        end
        REG_RATE: begin
          rate_d = be_merge(rate_q, i_avs_writedata, i_avs_byteenable);
        end
        REG_STATUS: begin
          st_clr = i_avs_byteenable[0] ? i_avs_writedata[ST_W-1:0] : '0;
        end
        REG_MASK: begin
          wmerged = be_merge({{(DATA_W-ST_W){1'b0}}, mask_q}, i_avs_writedata, i_avs_byteenable);
          mask_d = wmerged[ST_W-1:0];
        end
        default: ;
      endcase
    end
    if (i_avs_read && wait_q) begin
      case (i_avs_address)
        REG_CTRL: rdata_d = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        REG_BUCKET: rdata_d = {{(DATA_W-BKT_W){1'b0}}, bkt_q};
        REG_RATE: rdata_d = rate_q;
        REG_OCC: rdata_d = occ_q[FRAC_W +: DATA_W];
        REG_STATUS: rdata_d = {{(DATA_W-ST_W){1'b0}}, st_q};
        REG_MASK: rdata_d = {{(DATA_W-ST_W){1'b0}}, mask_q};
        REG_TICK: rdata_d = tick_q;
        default: rdata_d = '0;
      endcase
    end
    // a new event wins over a simultaneous clear
    st_d = (st_q & ~st_clr) | ev;
    irq_d = |(st_d & mask_d);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= RST_CTRL;
      bkt_q <= RST_BUCKET;
      rate_q <= RST_RATE;
      mask_q <= RST_MASK;
      st_q <= '0;
      rdata_q <= '0;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      bkt_q <= bkt_d;
      rate_q <= rate_d;
      mask_q <= mask_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      irq_q <= irq_d;
    end
  end

  always_comb begin
    occ_d = cred;
    shp_d = shp_q;
    plen_d = plen_q;
    time_d = time_q;
    tick_d = tick_q + 1'b1;
    vld_d = 1'b0;
    conf_d = conf_q;
    rel_d = 1'b0;
    ev = '0;
    unique case (shp_q)
      TBMS_HOLD: begin
        if (cred >= pfix) begin
          occ_d = cred - pfix;
          shp_d = TBMS_IDLE;
          rel_d = 1'b1;
          vld_d = 1'b1;
          conf_d = 1'b1;
          time_d = tick_q;
          ev[ST_CONFORM_BIT] = 1'b1;
          ev[ST_RELEASE_BIT] = 1'b1;
        end
      end
      TBMS_IDLE: begin
        if (arrive && shape) begin
          if (cred >= lfix) begin
            occ_d = cred - lfix;
            rel_d = 1'b1;
            vld_d = 1'b1;
            conf_d = 1'b1;
            time_d = tick_q;
            ev[ST_CONFORM_BIT] = 1'b1;
            ev[ST_RELEASE_BIT] = 1'b1;
          end else begin
            shp_d = TBMS_HOLD;
            plen_d = i_pkt_len;
          end
        end else if (arrive) begin
          vld_d = 1'b1;
          if (strict) begin
            conf_d = (cred - lfix >= 0);
          end else begin
            conf_d = !cred[OCC_W-1];
          end
          if (conf_d) begin
            occ_d = cred - lfix;
          end
          ev[ST_CONFORM_BIT] = conf_d;
          ev[ST_NONCONF_BIT] = !conf_d;
        end
      end
    endcase
    ready_d = (shp_d == TBMS_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      occ_q <= RST_OCC;
      shp_q <= TBMS_IDLE;
      plen_q <= '0;
      time_q <= '0;
      tick_q <= '0;
      ready_q <= 1'b1;
      vld_q <= 1'b0;
      conf_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      occ_q <= occ_d;
      shp_q <= shp_d;
      plen_q <= plen_d;
      time_q <= time_d;
      tick_q <= tick_d;
      ready_q <= ready_d;
      vld_q <= vld_d;
      conf_q <= conf_d;
      rel_q <= rel_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_pkt_ready = ready_q;
  assign o_verdict_valid = vld_q;
  assign o_verdict_conform = conf_q;
  assign o_release_valid = rel_q;
  assign o_release_eligible_time = time_q;
  assign o_irq = irq_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_hold_short;
    shp_q == TBMS_HOLD && cred < pfix;
  endsequence
  sequence s_hold_enough;
    shp_q == TBMS_HOLD && cred >= pfix;
  endsequence
  sequence s_meter_arrival;
    arrive && !shape;
  endsequence

  AST_FULL_IDLE_HOLDS: assert property (
    occ_q == bfix && !i_pkt_valid && shp_q == TBMS_IDLE && !wr_bucket
    |=> occ_q == $past(occ_q))
    else $error("full idle bucket changed");
  AST_CAP: assert property (!wr_bucket |=> occ_q <= bfix)
    else $error("occupancy above bucket size");
  AST_CREDIT_SUM: assert property (
    !arrive && shp_q == TBMS_IDLE && $past(shp_q) == TBMS_IDLE && $past(occ_q) < 0
      && !$past(arrive)
    |-> occ_q == (($past(occ_q) + $past(rate_x) > $past(bfix)) ? $past(bfix)
                  : $past(occ_q) + $past(rate_x)))
    else $error("credit not summed with negative occupancy");
  AST_LOOSE_NEG: assert property (
    s_meter_arrival ##0 (!strict && cred < 0) |=> o_verdict_valid && !o_verdict_conform
      && occ_q == $past(cred))
    else $error("loose meter accepted at negative occupancy");
  AST_LOOSE_POS: assert property (
    s_meter_arrival ##0 (!strict && cred >= 0) |=> o_verdict_valid && o_verdict_conform
      && occ_q == $past(cred) - $past(lfix))
    else $error("loose meter failed to accept and debit");
  AST_STRICT_OK: assert property (
    s_meter_arrival ##0 (strict && cred >= lfix) |=> o_verdict_conform
      && occ_q == $past(cred) - $past(lfix))
    else $error("strict conforming packet mishandled");
  AST_STRICT_NO: assert property (
    s_meter_arrival ##0 (strict && cred < lfix) |=> !o_verdict_conform && occ_q == $past(cred))
    else $error("strict non-conforming packet mishandled");
  AST_SHAPE_WAIT: assert property (s_hold_short |=> !o_release_valid && !o_pkt_ready)
    else $error("shaped packet released before credit");
  AST_SHAPE_GO: assert property (
    s_hold_enough |=> o_release_valid && o_pkt_ready && o_release_eligible_time == $past(tick_q))
    else $error("shaped packet not released when eligible");
  AST_MIN_BURST: assert property (bfix >= len_fix('0) + (1 <<< (FRAC_W-BIT_SH)))
    else $error("bucket below one bit");
  AST_IRQ: assert property (|(st_q & mask_q) |-> o_irq)
    else $error("interrupt missing");
endmodule // tbms_top

// ===== verif/tbms_up_model.sv
// upstream packet source model: offers one packet at a time to the meter
// assumes the meter's ready is a registered level on i_clk
`timescale 1ns/1ps
module tbms_up_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [tbms_pkg::LEN_W-1:0] o_len
);
  import tbms_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_len = 16'h5a5a;
  end
  // holds the packet until the edge that takes it, then scrambles the length
  task automatic send(input logic [LEN_W-1:0] len);
    o_valid <= 1'b1;
    o_len <= len;
    @(posedge i_clk);
    while (!i_ready) begin
      @(posedge i_clk);
    end
    o_valid <= 1'b0;
    o_len <= ~len;
  endtask
endmodule // tbms_up_model

// ===== verif/tb_tbms_top.sv
// testbench for the token bucket meter and shaper: registers, metering, shaping, interrupt
// assumes the upstream model tbms_up_model and a 200 MHz clock
`timescale 1ns/1ps
module tb_tbms_top;
  import tbms_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wd = 32'h0;
  logic [BE_W-1:0] be = 4'hf;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] rq;
  logic [DATA_W-1:0] t0;
  logic wq, pv, prdy, vv, vc, rv, irq;
  logic [LEN_W-1:0] plen;
  logic [TIME_W-1:0] elig;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 30188;
  int cyc = 0;
  int occ;
  int n;

  always #2.5 i_clk = ~i_clk;

  tbms_top tbms_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rq),
    .o_avs_waitrequest(wq), .i_pkt_valid(pv), .i_pkt_len(plen), .o_pkt_ready(prdy),
    .o_verdict_valid(vv), .o_verdict_conform(vc), .o_release_valid(rv),
    .o_release_eligible_time(elig), .o_irq(irq));
  tbms_up_model up_inst (.i_clk(i_clk), .i_ready(prdy), .o_valid(pv), .o_len(plen));

  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request stands until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge i_clk);
    while (wq) begin
      @(posedge i_clk);
    end
    rdat = rq;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rdreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, 32'h0);
    check(rdat, e);
  endtask

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask

  // expected verdict from the bench's own occupancy, with credit frozen
  function automatic logic judge(input logic strict, input int len);
    logic ok;
    ok = strict ? (occ >= len) : (occ >= 0);
    if (ok) occ -= len;
    return ok;
  endfunction

  task automatic pkt(input int len, input logic s);
    logic e;
    e = judge(s, len);
    up_inst.send(LEN_W'(len));
    @(negedge i_clk);
    check(vv, 1'b1);
    check(vc, e);
    @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim;
    end
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdreg(REG_OCC, 32'h5dc);
    rdreg(REG_BUCKET, 32'h2ee0);
    rdreg(REG_RATE, 32'h10000);
    rdreg(REG_MASK, 32'h0);
    rdreg(5'h1c, 32'h0);
    repeat (40) @(posedge i_clk);
    rdreg(REG_OCC, 32'h5dc);
    wreg(REG_RATE, 32'h0);
    wreg(REG_CTRL, 32'h1);
    occ = 1500;
    // strict packets stay below the bucket size
    repeat (12) pkt(1 + $unsigned($random(seed)) % 400, 1'b1);
    rdreg(REG_OCC, occ);
    pkt(occ + 1, 1'b1);
    pkt(occ, 1'b1);
    wreg(REG_CTRL, 32'h0);
    pkt(1000, 1'b0);
    pkt(40, 1'b0);
    rdreg(REG_OCC, occ);
    wreg(REG_RATE, 32'h10000);
    bus(1'b0, REG_OCC, 32'h0);
    check($signed(rdat) > occ && $signed(rdat) < occ + 20, 1'b1);
    wreg(REG_RATE, 32'h7fffffff);
    repeat (4) @(posedge i_clk);
    rdreg(REG_OCC, 32'h5dc);
    occ = 1500;
    pkt(1, 1'b0);
    check(irq, 1'b0);
    wreg(REG_MASK, 32'h2);
    repeat (2) @(negedge i_clk);
    check(irq, 1'b1);
    @(posedge i_clk);
    wreg(REG_STATUS, 32'h2);
    repeat (2) @(negedge i_clk);
    check(irq, 1'b0);
    @(posedge i_clk);
    rdreg(REG_STATUS, 32'h1);
    wreg(REG_RATE, 32'h0);
    wreg(REG_BUCKET, 32'h0);
    rdreg(REG_OCC, 32'h0);
    occ = 0;
    pkt(1500, 1'b0);
    pkt(1, 1'b0);
    wreg(REG_BUCKET, 32'h2ee0);
    wreg(REG_RATE, 32'h7fffffff);
    wreg(REG_RATE, 32'h0);
    wreg(REG_CTRL, 32'h3);
    occ = 1500;
    pkt(1300, 1'b1);
    up_inst.send(16'h01f4);
    @(negedge i_clk);
    check(prdy, 1'b0);
    @(posedge i_clk);
    bus(1'b0, REG_TICK, 32'h0);
    t0 = rdat;
    wreg(REG_RATE, 32'h10000);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (rv !== 1'b1 && n < 400);
    check(rv, 1'b1);
    check(vc, 1'b1);
    check(n > 290 && n < 305, 1'b1);
    check(elig - t0 > 297 && elig - t0 < 312, 1'b1);
    @(posedge i_clk);
    // reset in mid-run, then a write on one byte lane only
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdreg(REG_OCC, 32'h5dc);
    rdreg(REG_CTRL, 32'h0);
    be <= 4'h2;
    wreg(REG_BUCKET, 32'h00aabbcc);
    be <= 4'hf;
    rdreg(REG_BUCKET, 32'h0000bbe0);
    end_sim;
  end
endmodule // tb_tbms_top
